// ---- verilog/rx_status_pkg.sv ----
// Shared constants, register map and carrier types of the receive control block
package rx_status_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int DIV_W = 16;
	localparam int CHAR_W = 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
	localparam logic [ADDR_W-1:0] DATA_OFFSET = 12'h008;
	localparam logic [ADDR_W-1:0] DIVISOR_OFFSET = 12'h00c;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 12'h010;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 12'h014;

	// Control register field positions
	localparam int CTRL_SYNC_BIT = 0;
	localparam int CTRL_NINE_BIT = 1;
	localparam int CTRL_CONTINUOUS_RECEIVE_ENABLE_BIT = 2;
	localparam int CTRL_SINGLE_RECEIVE_ENABLE_BIT = 3;
	localparam int CTRL_ADDR_BIT = 4;

	// Status register field positions
	localparam int STAT_NINTH_BIT = 0;
	localparam int STAT_OVERRUN_BIT = 1;
	localparam int STAT_FRAMING_BIT = 2;
	localparam int STAT_AVAIL_BIT = 3;
	localparam int STAT_BUSY_BIT = 4;

	// Interrupt status and mask field positions
	localparam int IRQ_W = 3;
	localparam int IRQ_CHAR_BIT = 0;
	localparam int IRQ_FRAMING_BIT = 1;
	localparam int IRQ_OVERRUN_BIT = 2;

	// Reset values
	localparam logic [DIV_W-1:0] DIVISOR_RESET = 16'h0364;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

	typedef enum logic {
		ASYNC_MODE,
		SYNC_MODE
	} mode_type;

	typedef struct packed {
		logic address_detect_enable;
		logic single_receive_enable;
		logic continuous_receive_enable;
		logic nine_bit_receive_select;
		mode_type mode;
	} ctrl_type;

	typedef struct packed {
		logic frame_bad;
		logic ninth;
		logic [CHAR_W-1:0] data;
	} char_type;
endpackage

// ---- verilog/rx_shifter.sv ----
// Serial receive shift engine for asynchronous and synchronous character framing
`timescale 1ns/1ps
module rx_shifter
	import rx_status_pkg::*;
#(
	parameter int DIV_WIDTH = DIV_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire mode_type mode,
	input wire logic nine_bit,
	input wire logic [DIV_WIDTH-1:0] divisor,
	input wire logic rx_line,
	input wire logic sync_clk,
	output logic busy,
	output logic done,
	output char_type char_out
);
	typedef enum logic [1:0] {
		IDLE_S,
		START_S,
		DATA_S,
		STOP_S
	} shift_state_type;

	if (DIV_WIDTH < 2) begin : g_check
		$error("rx_shifter: divisor width too small");
	end

	shift_state_type state_ff;
	logic [DIV_WIDTH-1:0] cnt_ff;
	logic [3:0] idx_ff;
	logic [CHAR_W:0] receive_shift_register_ff;
	logic sync_prev_ff;
	logic done_ff;
	char_type char_ff;
	logic sync_rise;
	logic last_bit;
	logic sample;

	assign sync_rise = sync_clk && !sync_prev_ff;
	assign last_bit = nine_bit ? (idx_ff == 4'(CHAR_W)) : (idx_ff == 4'(CHAR_W - 1));
	assign sample = (mode == SYNC_MODE) ? sync_rise : (cnt_ff == '0);
	assign busy = (state_ff != IDLE_S);
	assign done = done_ff;
	assign char_out = char_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_prev_ff <= 1'b0;
		end else begin
			sync_prev_ff <= sync_clk;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= IDLE_S;
			cnt_ff <= '0;
			idx_ff <= '0;
			receive_shift_register_ff <= '0;
			done_ff <= 1'b0;
			char_ff <= '0;
		end else begin
			done_ff <= 1'b0;
			if (!enable) begin
				state_ff <= IDLE_S;
			end else begin
				case (state_ff)
					IDLE_S: begin
						receive_shift_register_ff <= '0;
						if (mode == SYNC_MODE && sync_rise) begin
							receive_shift_register_ff[0] <= rx_line;
							idx_ff <= 4'd1;
							state_ff <= DATA_S;
						end else if (mode == ASYNC_MODE && !rx_line) begin
							cnt_ff <= divisor >> 1;
							state_ff <= START_S;
						end
					end
					START_S: begin
						if (cnt_ff == '0) begin
							cnt_ff <= divisor - 1'b1;
							idx_ff <= '0;
							state_ff <= rx_line ? IDLE_S : DATA_S;
						end else begin
							cnt_ff <= cnt_ff - 1'b1;
						end
					end
					DATA_S: begin
						if (mode == ASYNC_MODE) begin
							cnt_ff <= (cnt_ff == '0) ? divisor - 1'b1 : cnt_ff - 1'b1;
						end
						if (sample) begin
							receive_shift_register_ff[idx_ff] <= rx_line;
							idx_ff <= idx_ff + 1'b1;
							if (last_bit && mode == SYNC_MODE) begin
								done_ff <= 1'b1;
								char_ff.data <= receive_shift_register_ff[CHAR_W-1:0];
								char_ff.ninth <= rx_line;
								if (!nine_bit) begin
									char_ff.data[CHAR_W-1] <= rx_line;
									char_ff.ninth <= 1'b0;
								end
								char_ff.frame_bad <= 1'b0;
								state_ff <= IDLE_S;
							end else if (last_bit) begin
								state_ff <= STOP_S;
							end
						end
					end
					STOP_S: begin
						if (cnt_ff == '0) begin
							done_ff <= 1'b1;
							char_ff.data <= receive_shift_register_ff[CHAR_W-1:0];
							char_ff.ninth <= nine_bit && receive_shift_register_ff[CHAR_W];
							char_ff.frame_bad <= !rx_line;
							state_ff <= IDLE_S;
						end else begin
							cnt_ff <= cnt_ff - 1'b1;
						end
					end
					default: state_ff <= IDLE_S;
				endcase
			end
		end
	end
endmodule // rx_shifter

// ---- verilog/rx_control_status.sv ----
// Receive control, status flags and APB register file of the serial port
//
// Behaviour
// - Async mode: continuous receive enable turns receiver on, clearing it turns off.
// - Sync mode: continuous enable keeps receiving until cleared; clearing stops it.
// - Sync mode: continuous enable overrides single receive enable when both set.
// - 9-bit async with address detect: load and interrupt only if ninth bit set.
// - 9-bit async without address detect: accept all, ninth bit free for parity.
// - 8-bit async mode ignores the address detect enable completely.
// - Framing flag set for bad character, refreshed with next loaded character.
// - Overrun flag set on overrun, cleared whenever continuous enable is cleared.
// - Ninth received bit captured into a status bit; no parity computed.
`timescale 1ns/1ps
module rx_control_status
	import rx_status_pkg::*;
#(
	parameter logic [DIV_W-1:0] DIVISOR_DEFAULT = DIVISOR_RESET
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_line,
	input wire logic sync_clk,
	output logic irq
);
	if (DIVISOR_DEFAULT < 2) begin : g_check
		$error("rx_control_status: divisor default too small");
	end

	function automatic logic [DATA_W-1:0] widen(input logic [DATA_W-1:0] v);
		widen = v;
	endfunction

	ctrl_type ctrl_ff;
	logic [DIV_W-1:0] divisor_ff;
	logic [CHAR_W-1:0] receive_data_buffer_ff;
	logic received_ninth_bit_ff;
	logic framing_error_flag_ff;
	logic overrun_error_flag_ff;
	logic avail_ff;
	logic [IRQ_W-1:0] irq_status_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic irq_ff;

	logic access;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic [DATA_W-1:0] nxt_rdata;
	logic rx_enable;
	logic rx_busy;
	logic char_done;
	char_type char_in;
	logic addr_filter;
	logic accept;
	logic load;
	logic overrun;
	logic data_read;
	logic [IRQ_W-1:0] irq_events;

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;

	// APB access phase completes on the second cycle of penable
	assign access = psel && penable && pready_ff;
	assign wr_en = access && pwrite && !pslverr_ff;
	assign rd_en = access && !pwrite && !pslverr_ff;

	always_comb begin
		mapped = 1'b1;
		nxt_rdata = '0;
		if (paddr == CTRL_OFFSET) begin
			nxt_rdata = widen({27'h0, ctrl_type'(ctrl_ff)});
		end else if (paddr == STATUS_OFFSET) begin
			nxt_rdata[STAT_NINTH_BIT] = ctrl_ff.nine_bit_receive_select
				&& received_ninth_bit_ff;
			nxt_rdata[STAT_OVERRUN_BIT] = overrun_error_flag_ff;
			nxt_rdata[STAT_FRAMING_BIT] = framing_error_flag_ff;
			nxt_rdata[STAT_AVAIL_BIT] = avail_ff;
			nxt_rdata[STAT_BUSY_BIT] = rx_busy;
		end else if (paddr == DATA_OFFSET) begin
			nxt_rdata[CHAR_W-1:0] = receive_data_buffer_ff;
		end else if (paddr == DIVISOR_OFFSET) begin
			nxt_rdata[DIV_W-1:0] = divisor_ff;
		end else if (paddr == IRQ_STATUS_OFFSET) begin
			nxt_rdata[IRQ_W-1:0] = irq_status_ff;
		end else if (paddr == IRQ_MASK_OFFSET) begin
			nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
		end else begin
			mapped = 1'b0;
		end
	end

	// Bus handshake: one wait state, error on unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			if (psel && penable && !pready_ff) begin
				pready_ff <= 1'b1;
				pslverr_ff <= !mapped;
				prdata_ff <= (!pwrite && mapped) ? nxt_rdata : '0;
			end else begin
				pready_ff <= 1'b0;
				pslverr_ff <= 1'b0;
			end
		end
	end

	// Receiver enable by mode
	always_comb begin
		if (ctrl_ff.mode == ASYNC_MODE) begin
			rx_enable = ctrl_ff.continuous_receive_enable;
		end else begin
			rx_enable = ctrl_ff.continuous_receive_enable
				|| ctrl_ff.single_receive_enable;
		end
	end

	rx_shifter #(
		.DIV_WIDTH(DIV_W)
	) u_shifter (
		.pclk(pclk),
		.presetn(presetn),
		.enable(rx_enable),
		.mode(ctrl_ff.mode),
		.nine_bit(ctrl_ff.nine_bit_receive_select),
		.divisor(divisor_ff),
		.rx_line(rx_line),
		.sync_clk(sync_clk),
		.busy(rx_busy),
		.done(char_done),
		.char_out(char_in)
	);

	// Address filtering only in 9-bit asynchronous mode
	assign addr_filter = (ctrl_ff.mode == ASYNC_MODE) && ctrl_ff.nine_bit_receive_select
		&& ctrl_ff.address_detect_enable;
	assign accept = !addr_filter || char_in.ninth;
	assign overrun = char_done && accept && avail_ff;
	assign load = char_done && accept && !avail_ff;
	assign data_read = rd_en && (paddr == DATA_OFFSET);

	// Control register; single receive ends after one character unless continuous overrides
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= '0;
		end else begin
			if (wr_en && paddr == CTRL_OFFSET) begin
				ctrl_ff <= ctrl_type'(pwdata[4:0]);
			end else if (char_done && ctrl_ff.mode == SYNC_MODE
				&& !ctrl_ff.continuous_receive_enable) begin
				ctrl_ff.single_receive_enable <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divisor_ff <= DIVISOR_DEFAULT;
		end else if (wr_en && paddr == DIVISOR_OFFSET && pwdata[DIV_W-1:0] > 1) begin
			divisor_ff <= pwdata[DIV_W-1:0];
		end
	end

	// Receive buffer with its ninth bit and framing flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_data_buffer_ff <= '0;
			received_ninth_bit_ff <= 1'b0;
			framing_error_flag_ff <= 1'b0;
		end else if (load) begin
			receive_data_buffer_ff <= char_in.data;
			received_ninth_bit_ff <= char_in.ninth;
			framing_error_flag_ff <= char_in.frame_bad;
		end
	end

	// Data available: a new load wins over a read in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			avail_ff <= 1'b0;
		end else if (load) begin
			avail_ff <= 1'b1;
		end else if (data_read) begin
			avail_ff <= 1'b0;
		end
	end

	// Overrun flag, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_error_flag_ff <= 1'b0;
		end else if (overrun) begin
			overrun_error_flag_ff <= 1'b1;
		end else if (!ctrl_ff.continuous_receive_enable) begin
			overrun_error_flag_ff <= 1'b0;
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	assign irq_events = {overrun, load && char_in.frame_bad, load};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_ff <= '0;
		end else begin
			if (wr_en && paddr == IRQ_STATUS_OFFSET) begin
				irq_status_ff <= (irq_status_ff & ~pwdata[IRQ_W-1:0]) | irq_events;
			end else begin
				irq_status_ff <= irq_status_ff | irq_events;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_ff <= IRQ_MASK_RESET;
		end else if (wr_en && paddr == IRQ_MASK_OFFSET) begin
			irq_mask_ff <= pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_status_ff & irq_mask_ff);
		end
	end
endmodule // rx_control_status

// ---- sim/rx_control_status_monitor.sv ----
// Bus timing and status flag checker of the receive control block
`timescale 1ns/1ps
module rx_control_status_monitor
	import rx_status_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_line,
	input wire logic sync_clk,
	input wire logic irq
);
	logic [4:0] ctrl_seen_ff;
	logic hit;
	logic stat_rd;

	assign hit = paddr inside {CTRL_OFFSET, STATUS_OFFSET, DATA_OFFSET, DIVISOR_OFFSET,
		IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET};
	assign stat_rd = pready && !pwrite && paddr == STATUS_OFFSET;

	// Control value last written over the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_seen_ff <= 5'h00;
		end else if (psel && penable && pready && pwrite && paddr == CTRL_OFFSET) begin
			ctrl_seen_ff <= pwdata[4:0];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_after_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && penable))
		else $error("pready outside access phase");
	error_unmapped_a: assert property (pready && !hit |-> pslverr)
		else $error("unmapped access without error");
	error_only_unmapped_a: assert property (pslverr |-> pready && !hit)
		else $error("error on mapped access");
	write_reads_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("read data on write");
	overrun_cleared_a: assert property (stat_rd && !ctrl_seen_ff[CTRL_CONTINUOUS_RECEIVE_ENABLE_BIT] |->
		!prdata[STAT_OVERRUN_BIT]) else $error("overrun flag with receiver off");
	ninth_in_eight_a: assert property (stat_rd && !ctrl_seen_ff[CTRL_NINE_BIT] |->
		!prdata[STAT_NINTH_BIT]) else $error("ninth bit set in eight bit mode");
	mask_silences_a: assert property (pready && pwrite && paddr == IRQ_MASK_OFFSET &&
		pwdata[2:0] == 3'h0 |=> ##1 !irq) else $error("irq high with all masked");
endmodule // rx_control_status_monitor

bind rx_control_status rx_control_status_monitor u_mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
	.sync_clk(sync_clk), .irq(irq));

// ---- sim/rx_far_end.sv ----
// Remote serial transmitter driving the receive line and shift clock
`timescale 1ns/1ps
module rx_far_end #(
	parameter int DIV = 4
) (
	input wire logic pclk,
	output logic rx_line,
	output logic sync_clk
);
	initial begin
		rx_line = 1'b1;
		sync_clk = 1'b0;
	end

	// Low start bit, data LSB first, ninth bit last, stop level from caller
	task automatic send_async(input logic [8:0] bits, input int nbits, input logic stop);
		for (int i = -1; i <= nbits; i++) begin
			rx_line <= (i < 0) ? 1'b0 : (i == nbits) ? stop : bits[i];
			repeat (DIV) @(posedge pclk);
		end
		rx_line <= 1'b1;
		repeat (DIV) @(posedge pclk);
	endtask

	// Shift clock runs only within the frame; line toggles away afterwards
	task automatic send_sync(input logic [7:0] bits);
		for (int i = 0; i < 8; i++) begin
			rx_line <= bits[i];
			repeat (3) @(posedge pclk);
			sync_clk <= 1'b1;
			repeat (3) @(posedge pclk);
			sync_clk <= 1'b0;
		end
		rx_line <= ~bits[7];
		@(posedge pclk);
	endtask
endmodule // rx_far_end

// ---- sim/test_rx_control_status.sv ----
// Self-checking bench of the receive control block
`timescale 1ns/1ps
module test_rx_control_status
	import rx_status_pkg::*;
();
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, sync_clk, irq;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic err_seen;
	int errors = 0;
	int samples_checked = 0;

	rx_control_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
		.sync_clk(sync_clk), .irq(irq));
	rx_far_end #(.DIV(4)) u_far (.pclk(pclk), .rx_line(rx_line), .sync_clk(sync_clk));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic report_and_stop();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr,
		input logic [DATA_W-1:0] data);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
		end
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic expect_reg(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp);
		apb(1'b0, addr, 32'h0);
		check(rd, exp);
	endtask

	// Send one character (nbits 0 means synchronous), then check status, and data only when st has the available bit set
	task automatic rx_char(input logic [8:0] bits, input int nbits, input logic stop,
		input logic [DATA_W-1:0] st, input logic [DATA_W-1:0] dat);
		if (nbits == 0) begin
			u_far.send_sync(bits[7:0]);
		end else begin
			u_far.send_async(bits, nbits, stop);
		end
		repeat (2) @(posedge pclk);
		expect_reg(STATUS_OFFSET, st);
		if (st[STAT_AVAIL_BIT]) begin
			expect_reg(DATA_OFFSET, dat);
		end
	endtask

	task automatic irq_is(input logic exp);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, {31'h0, exp});
	endtask

	initial begin
		repeat (30000) @(posedge pclk);
		errors++;
		report_and_stop();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		expect_reg(CTRL_OFFSET, 32'h0);
		expect_reg(DIVISOR_OFFSET, {16'h0, DIVISOR_RESET});
		expect_reg(IRQ_MASK_OFFSET, 32'h0);
		expect_reg(STATUS_OFFSET, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		check({31'h0, err_seen}, 32'h1);
		apb(1'b1, DIVISOR_OFFSET, 32'h1);
		expect_reg(DIVISOR_OFFSET, {16'h0, DIVISOR_RESET});
		apb(1'b1, DIVISOR_OFFSET, 32'h4);
		apb(1'b1, IRQ_MASK_OFFSET, 32'h7);
		apb(1'b1, CTRL_OFFSET, 32'h06);
		rx_char(9'h1a5, 9, 1'b1, 32'h09, 32'ha5);
		irq_is(1'b1);
		expect_reg(IRQ_STATUS_OFFSET, 32'h1);
		apb(1'b1, IRQ_STATUS_OFFSET, 32'h7);
		irq_is(1'b0);
		apb(1'b1, IRQ_MASK_OFFSET, 32'h0);
		rx_char(9'h03c, 9, 1'b0, 32'h0c, 32'h3c);
		expect_reg(STATUS_OFFSET, 32'h04);
		irq_is(1'b0);
		expect_reg(IRQ_STATUS_OFFSET, 32'h3);
		apb(1'b1, IRQ_MASK_OFFSET, 32'h7);
		irq_is(1'b1);
		apb(1'b1, IRQ_STATUS_OFFSET, 32'h7);
		rx_char(9'h055, 9, 1'b1, 32'h08, 32'h55);
		apb(1'b1, CTRL_OFFSET, 32'h16);
		rx_char(9'h0c3, 9, 1'b1, 32'h00, 32'h0);
		rx_char(9'h1c3, 9, 1'b1, 32'h09, 32'hc3);
		apb(1'b1, CTRL_OFFSET, 32'h14);
		rx_char(9'h081, 8, 1'b1, 32'h08, 32'h81);
		apb(1'b1, CTRL_OFFSET, 32'h04);
		u_far.send_async(9'h011, 8, 1'b1);
		rx_char(9'h022, 8, 1'b1, 32'h0a, 32'h11);
		expect_reg(IRQ_STATUS_OFFSET, 32'h5);
		apb(1'b1, CTRL_OFFSET, 32'h00);
		expect_reg(STATUS_OFFSET, 32'h00);
		rx_char(9'h033, 8, 1'b1, 32'h00, 32'h0);
		apb(1'b1, CTRL_OFFSET, 32'h0d);
		rx_char(9'h05a, 0, 1'b1, 32'h08, 32'h5a);
		rx_char(9'h0c1, 0, 1'b1, 32'h08, 32'hc1);
		apb(1'b1, CTRL_OFFSET, 32'h01);
		rx_char(9'h077, 0, 1'b1, 32'h00, 32'h0);
		report_and_stop();
	end
endmodule // test_rx_control_status
